// ### hw/cell_pkg.sv
// constants, field layouts and carrier types for the logic cell
package cell_pkg;

    localparam int          DATA_WIDTH    = 32;
    localparam int          ADDR_WIDTH    = 4;
    localparam int          LUT_BITS      = 16;
    localparam int          HALF_BITS     = 8;
    localparam int          INDEX_WIDTH   = 4;
    localparam int          CLUSTER_WIDTH = 8;

    localparam logic [ADDR_WIDTH-1:0] ADDR_LUT    = 4'h0;
    localparam logic [ADDR_WIDTH-1:0] ADDR_CTRL   = 4'h4;
    localparam logic [ADDR_WIDTH-1:0] ADDR_POS    = 4'h8;
    localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 4'hC;

    localparam logic [LUT_BITS-1:0]   LUT_RESET   = 16'h0000;
    localparam logic [DATA_WIDTH-1:0] READ_IDLE   = 32'h0000_0000;

    // cell position inside its cluster, zero based
    localparam logic [INDEX_WIDTH-1:0] FIRST_CELL  = 4'h0;
    localparam logic [INDEX_WIDTH-1:0] SECOND_CELL = 4'h1;

    // a long chain lands this many clusters further along the row
    localparam logic [CLUSTER_WIDTH-1:0] CLUSTER_SKIP = 8'h02;

    localparam logic STATE_CLEARED = 1'b0;

    typedef enum logic [1:0]
    {
        MODE_NORMAL  = 2'b00,
        MODE_ARITH   = 2'b01,
        MODE_COUNTER = 2'b11
    } cell_mode_t;

    typedef struct packed
    {
        logic four;
        logic three;
        logic two;
        logic one;
    } cell_inputs_t;

    typedef struct packed
    {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic                  wr;
        logic                  rd;
    } bus_req_t;

    typedef struct packed
    {
        logic       ctrl_gen_en;
        logic       carry_sink;
        logic       fast_feedback;
        logic       count_use_dir;
        logic       hold_on_load;
        logic       clr_en;
        logic       clr_sel;
        logic       preset_mode;
        logic       reg_bypass;
        logic       cascade_or;
        logic       cascade_en;
        logic       use_carry_in;
        cell_mode_t mode;
    } cell_ctrl_t;

    localparam int         CTRL_WIDTH = $bits(cell_ctrl_t);
    localparam cell_ctrl_t CTRL_RESET = '0;

    typedef struct packed
    {
        logic [CLUSTER_WIDTH-1:0] cluster_index;
        logic [INDEX_WIDTH-1:0]   cell_index;
    } cell_pos_t;

    localparam int        POS_WIDTH = $bits(cell_pos_t);
    localparam cell_pos_t POS_RESET = '0;

    localparam int STATUS_WIDTH = 4;

endpackage

// ### hw/logic_cell.sv
// one logic cell: lookup table, register, carry and cascade chains, counter mode
//
// Behaviour
// - a sixteen-entry table realises any function of four inputs
// - incoming carry feeds the table and the onward carry chain
// - first cell of a cluster never joins a carry chain
// - last cell of a cluster carries to second cell two clusters on
// - no carry passes across the middle of the row
// - an extra sink cell drives the final carry onto routing
// - output is the register or the bypassed combinational value
// - normal mode table uses inputs one to four, carry or input three
// - normal mode table output merges with cascade in to cascade out
// - arithmetic lower half table gives sum of carry, input one, two
// - arithmetic upper half table gives carry out from the same three
// - arithmetic mode keeps cascade chain usable alongside carry chain
// - counter has enable, up/down, synchronous clear and load
// - cluster clear and load act on this register in every mode
// - counter uses data and carry tables, load mux, clear gate
// - synchronous clear or load override the cascade value
// - clear wins when clear and load arrive together
// - load can hold the register by reloading its own output
// - second cell may take its carry from its own register path
// - first cell inputs can drive cluster clear and load
// - asynchronous clear or preset controls are active low
// - device wide reset overrides all, presetting preset registers
`timescale 1ns/100ps

module logic_cell
#(
    parameter logic [cell_pkg::INDEX_WIDTH-1:0]   LAST_CELL         = 4'h9,
    parameter logic [cell_pkg::CLUSTER_WIDTH-1:0] LAST_LEFT_CLUSTER = 8'h0B
)
(
    input  wire logic                            clock_in,
    input  wire logic                            rst_in,
    input  wire cell_pkg::bus_req_t              bus_in,
    output      logic [cell_pkg::DATA_WIDTH-1:0] rdata_out,
    input  wire cell_pkg::cell_inputs_t          cell_data_in,
    input  wire logic                            carry_in,
    input  wire logic                            cascade_in,
    input  wire logic                            cluster_sync_clear_in,
    input  wire logic                            cluster_sync_load_in,
    input  wire logic                            cluster_control_one_n_in,
    input  wire logic                            cluster_control_two_n_in,
    input  wire logic                            device_wide_reset_n_in,
    output      logic                            cell_out,
    output      logic                            register_q_out,
    output      logic                            carry_out,
    output      logic                            cascade_out,
    output      logic                            cluster_clear_gen_out,
    output      logic                            cluster_load_gen_out
);

    // arithmetic mode splits the table by its top index bit

    function automatic logic lut_pick
    (
        input logic [cell_pkg::LUT_BITS-1:0]    mask,
        input logic [cell_pkg::INDEX_WIDTH-1:0] sel
    );
        lut_pick = mask[sel];
    endfunction

    // counter data table: toggles when the chain below says so
    function automatic logic count_data
    (
        input logic q,
        input logic chain,
        input logic enable
    );
        count_data = q ^ (enable & chain);
    endfunction

    // counter carry table: up passes on ones, down passes on zeros
    function automatic logic count_carry
    (
        input logic q,
        input logic chain,
        input logic enable,
        input logic up
    );
        count_carry = enable & chain & (up ? q : ~q);
    endfunction

    logic [cell_pkg::LUT_BITS-1:0]     lut_reg;
    cell_pkg::cell_ctrl_t              ctrl_reg;
    cell_pkg::cell_pos_t               pos_reg;
    logic [cell_pkg::DATA_WIDTH-1:0]   rdata_reg;
    logic                              state_reg;

    logic [cell_pkg::DATA_WIDTH-1:0]   rdata_next;
    logic                              state_next;
    logic [cell_pkg::STATUS_WIDTH-1:0] status_word;

    logic                              is_first;
    logic                              is_second;
    logic                              is_last;
    logic                              jump_out_blocked;
    logic                              jump_in_blocked;
    logic                              chain_in;
    logic                              q_value;
    logic                              table_out;
    logic                              carry_raw;
    logic                              merged;
    logic                              count_enable;
    logic                              count_up;
    logic                              load_data;
    logic                              reg_data;
    logic                              async_clear_n;

    assign is_first  = (pos_reg.cell_index == cell_pkg::FIRST_CELL);
    assign is_second = (pos_reg.cell_index == cell_pkg::SECOND_CELL);
    assign is_last   = (pos_reg.cell_index == LAST_CELL);

    // outgoing jump from the last cell would land past the row middle
    always_comb
    begin
        jump_out_blocked = 1'b0;
        if (is_last && (pos_reg.cluster_index <= LAST_LEFT_CLUSTER))
        begin
            jump_out_blocked = ((pos_reg.cluster_index + cell_pkg::CLUSTER_SKIP)
                               > LAST_LEFT_CLUSTER);
        end
    end

    // incoming jump into a second cell from the other half of the row
    always_comb
    begin
        jump_in_blocked = 1'b0;
        if (is_second && (pos_reg.cluster_index > LAST_LEFT_CLUSTER))
        begin
            jump_in_blocked = ((pos_reg.cluster_index - cell_pkg::CLUSTER_SKIP)
                              <= LAST_LEFT_CLUSTER);
        end
    end

    // register holds the inverted value in preset mode, so an asynchronous clear presets
    assign q_value        = state_reg ^ ctrl_reg.preset_mode;
    assign register_q_out = q_value;

    // carry seen by the tables and, through them, by the next stage
    always_comb
    begin
        chain_in = carry_in;
        if (is_first || jump_in_blocked)
        begin
            chain_in = 1'b0;
        end
        else if (ctrl_reg.fast_feedback && is_second &&
                 (ctrl_reg.mode == cell_pkg::MODE_COUNTER))
        begin
            // own register path replaces the chain: the bit steps whenever the counter is enabled
            chain_in = 1'b1;
        end
    end

    // direction and enable share the data inputs; one of them is fixed
    always_comb
    begin
        if (ctrl_reg.count_use_dir)
        begin
            count_enable = 1'b1;
            count_up     = cell_data_in.two;
        end
        else
        begin
            count_enable = cell_data_in.one;
            count_up     = 1'b1;
        end
    end

    // table outputs per mode
    always_comb
    begin
        table_out = 1'b0;
        carry_raw = 1'b0;
        case (ctrl_reg.mode)
            cell_pkg::MODE_NORMAL:
            begin
                table_out = lut_pick(lut_reg, {cell_data_in.four,
                                     (ctrl_reg.use_carry_in ? chain_in : cell_data_in.three),
                                     cell_data_in.two,
                                     cell_data_in.one});
            end
            cell_pkg::MODE_ARITH:
            begin
                table_out = lut_pick(lut_reg, {1'b0, chain_in,
                                     cell_data_in.two, cell_data_in.one});
                carry_raw = lut_pick(lut_reg, {1'b1, chain_in,
                                     cell_data_in.two, cell_data_in.one});
            end
            cell_pkg::MODE_COUNTER:
            begin
                table_out = count_data(q_value, chain_in, count_enable);
                carry_raw = count_carry(q_value, chain_in, count_enable, count_up);
            end
            default:
            begin
                table_out = 1'b0;
                carry_raw = 1'b0;
            end
        endcase
        if (ctrl_reg.carry_sink)
        begin
            // extra cell at the chain end: the carry itself becomes the output
            table_out = chain_in;
            carry_raw = 1'b0;
        end
    end

    // cascade merge is available in every mode
    always_comb
    begin
        merged = table_out;
        if (ctrl_reg.cascade_en)
        begin
            merged = ctrl_reg.cascade_or ? (table_out | cascade_in)
                                         : (table_out & cascade_in);
        end
    end

    assign cascade_out = merged;

    always_comb
    begin
        carry_out = carry_raw;
        if (is_first || jump_out_blocked)
        begin
            carry_out = 1'b0;
        end
    end

    assign cell_out = ctrl_reg.reg_bypass ? merged : q_value;

    // load mux then clear gate, so clear beats load beats cascade
    always_comb
    begin
        load_data = ctrl_reg.hold_on_load ? q_value : cell_data_in.three;
        reg_data  = cluster_sync_load_in ? load_data : merged;
        reg_data  = reg_data & ~cluster_sync_clear_in;
        state_next = reg_data ^ ctrl_reg.preset_mode;
    end

    // first cell may generate the cluster controls from its inputs
    always_comb
    begin
        cluster_clear_gen_out = 1'b0;
        cluster_load_gen_out  = 1'b0;
        if (is_first && ctrl_reg.ctrl_gen_en)
        begin
            cluster_clear_gen_out = cell_data_in.one;
            cluster_load_gen_out  = cell_data_in.two;
        end
    end

    // combined low-active clear; device reset wins over the selected control
    always_comb
    begin
        async_clear_n = device_wide_reset_n_in;
        if (ctrl_reg.clr_en)
        begin
            async_clear_n = device_wide_reset_n_in &
                            (ctrl_reg.clr_sel ? cluster_control_two_n_in
                                              : cluster_control_one_n_in);
        end
    end

    // the cell register; clear is the only asynchronous path
    always_ff @(posedge clock_in or negedge async_clear_n)
    begin
        if (!async_clear_n)
        begin
            state_reg <= cell_pkg::STATE_CLEARED;
        end
        else if (rst_in)
        begin
            state_reg <= cell_pkg::STATE_CLEARED;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // configuration writes
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            lut_reg <= cell_pkg::LUT_RESET;
        end
        else if (bus_in.wr && (bus_in.addr == cell_pkg::ADDR_LUT))
        begin
            lut_reg <= bus_in.wdata[cell_pkg::LUT_BITS-1:0];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctrl_reg <= cell_pkg::CTRL_RESET;
        end
        else if (bus_in.wr && (bus_in.addr == cell_pkg::ADDR_CTRL))
        begin
            ctrl_reg <= cell_pkg::cell_ctrl_t'(bus_in.wdata[cell_pkg::CTRL_WIDTH-1:0]);
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            pos_reg <= cell_pkg::POS_RESET;
        end
        else if (bus_in.wr && (bus_in.addr == cell_pkg::ADDR_POS))
        begin
            pos_reg <= cell_pkg::cell_pos_t'(bus_in.wdata[cell_pkg::POS_WIDTH-1:0]);
        end
    end

    assign status_word = {carry_out, cascade_out, cell_out, q_value};

    // read data only in the cycle after the strobe; unmapped reads give zero
    always_comb
    begin
        rdata_next = cell_pkg::READ_IDLE;
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                cell_pkg::ADDR_LUT:
                begin
                    rdata_next[cell_pkg::LUT_BITS-1:0] = lut_reg;
                end
                cell_pkg::ADDR_CTRL:
                begin
                    rdata_next[cell_pkg::CTRL_WIDTH-1:0] = ctrl_reg;
                end
                cell_pkg::ADDR_POS:
                begin
                    rdata_next[cell_pkg::POS_WIDTH-1:0] = pos_reg;
                end
                cell_pkg::ADDR_STATUS:
                begin
                    rdata_next[cell_pkg::STATUS_WIDTH-1:0] = status_word;
                end
                default:
                begin
                    rdata_next = cell_pkg::READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            rdata_reg <= cell_pkg::READ_IDLE;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_out = rdata_reg;

endmodule // logic_cell

// ### tb/cell_checker.sv
// concurrent checks on the logic cell ports
`timescale 1ns/100ps
module cell_checker
#(
    parameter logic [cell_pkg::INDEX_WIDTH-1:0]   LAST_CELL         = 4'h9,
    parameter logic [cell_pkg::CLUSTER_WIDTH-1:0] LAST_LEFT_CLUSTER = 8'h0B
)
(
    input wire logic                   clock_in,
    input wire logic                   rst_in,
    input wire cell_pkg::bus_req_t     bus_in,
    input wire logic [31:0]            rdata_out,
    input wire cell_pkg::cell_inputs_t cell_data_in,
    input wire logic                   carry_in,
    input wire logic                   cascade_in,
    input wire logic                   cluster_sync_clear_in,
    input wire logic                   cluster_sync_load_in,
    input wire logic                   cluster_control_one_n_in,
    input wire logic                   cluster_control_two_n_in,
    input wire logic                   device_wide_reset_n_in,
    input wire logic                   cell_out,
    input wire logic                   register_q_out,
    input wire logic                   carry_out,
    input wire logic                   cluster_clear_gen_out,
    input wire logic                   cluster_load_gen_out
);
    cell_pkg::cell_ctrl_t          ctrl_m;
    cell_pkg::cell_pos_t           pos_m;
    logic [cell_pkg::LUT_BITS-1:0] lut_m;
    logic                          mid_cell;
    logic                          async_idle;

    // configuration shadow from the write strobes
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            ctrl_m <= cell_pkg::CTRL_RESET;
            pos_m  <= cell_pkg::POS_RESET;
            lut_m  <= cell_pkg::LUT_RESET;
        end
        else if (bus_in.wr)
        begin
            if (bus_in.addr == cell_pkg::ADDR_CTRL)
                ctrl_m <= cell_pkg::cell_ctrl_t'(bus_in.wdata[cell_pkg::CTRL_WIDTH-1:0]);
            if (bus_in.addr == cell_pkg::ADDR_POS)
                pos_m <= cell_pkg::cell_pos_t'(bus_in.wdata[cell_pkg::POS_WIDTH-1:0]);
            if (bus_in.addr == cell_pkg::ADDR_LUT)
                lut_m <= bus_in.wdata[cell_pkg::LUT_BITS-1:0];
        end
    end

    // away from the ends and with no sink, chain input is carry_in and carry out is not blocked
    assign mid_cell = pos_m.cell_index > cell_pkg::SECOND_CELL && pos_m.cell_index < LAST_CELL && !ctrl_m.carry_sink;
    assign async_idle = device_wide_reset_n_in && cluster_control_one_n_in && cluster_control_two_n_in;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    a_read_idle_zero: assert property (!$past(bus_in.rd) |-> rdata_out == cell_pkg::READ_IDLE)
        else $error("read data not idle");
    a_normal_lut_out: assert property (ctrl_m.mode == cell_pkg::MODE_NORMAL && ctrl_m.reg_bypass
        && !ctrl_m.cascade_en && !ctrl_m.use_carry_in && !ctrl_m.carry_sink |-> cell_out == lut_m[cell_data_in])
        else $error("normal table output wrong");
    a_arith_sum_out: assert property (ctrl_m.mode == cell_pkg::MODE_ARITH && ctrl_m.reg_bypass && mid_cell
        && (!ctrl_m.cascade_en || !ctrl_m.cascade_or && cascade_in)
        |-> cell_out == lut_m[{1'b0, carry_in, cell_data_in.two, cell_data_in.one}])
        else $error("arithmetic sum wrong");
    a_arith_carry_out: assert property (ctrl_m.mode == cell_pkg::MODE_ARITH && mid_cell
        |-> carry_out == lut_m[{1'b1, carry_in, cell_data_in.two, cell_data_in.one}])
        else $error("arithmetic carry wrong");
    a_first_no_carry: assert property (pos_m.cell_index == cell_pkg::FIRST_CELL |-> !carry_out)
        else $error("first cell drives carry");
    a_ctrl_gen_map: assert property (pos_m.cell_index == cell_pkg::FIRST_CELL && ctrl_m.ctrl_gen_en
        |-> cluster_clear_gen_out == cell_data_in.one && cluster_load_gen_out == cell_data_in.two)
        else $error("cluster control generation wrong");
    a_wide_reset_q: assert property (!device_wide_reset_n_in |-> register_q_out == ctrl_m.preset_mode)
        else $error("device reset not applied");
    a_clear_wins: assert property (cluster_sync_clear_in && !bus_in.wr |=> register_q_out == ctrl_m.preset_mode)
        else $error("synchronous clear not applied");
    a_load_takes_data: assert property (cluster_sync_load_in && !cluster_sync_clear_in && !ctrl_m.hold_on_load
        && !ctrl_m.preset_mode && !bus_in.wr ##1 async_idle |-> register_q_out == $past(cell_data_in.three))
        else $error("synchronous load data wrong");
    a_load_holds_q: assert property (cluster_sync_load_in && !cluster_sync_clear_in && ctrl_m.hold_on_load
        && !bus_in.wr ##1 async_idle |-> $stable(register_q_out))
        else $error("hold on load changed the register");
endmodule // cell_checker

bind logic_cell cell_checker #(.LAST_CELL(LAST_CELL), .LAST_LEFT_CLUSTER(LAST_LEFT_CLUSTER)) checker_u
(
    .clock_in, .rst_in, .bus_in, .rdata_out, .cell_data_in, .carry_in, .cascade_in, .cluster_sync_clear_in,
    .cluster_sync_load_in, .cluster_control_one_n_in, .cluster_control_two_n_in, .device_wide_reset_n_in,
    .cell_out, .register_q_out, .carry_out, .cluster_clear_gen_out, .cluster_load_gen_out
);

// ### tb/cluster_side_model.sv
// neighbouring cells and cluster-wide controls facing one logic cell
`timescale 1ns/100ps
module cluster_side_model
(
    input  wire logic       carry_req_in,
    input  wire logic       cascade_req_in,
    input  wire logic       clear_req_in,
    input  wire logic       load_req_in,
    input  wire logic [2:0] async_low_req_in,
    output      logic       carry_out,
    output      logic       cascade_out,
    output      logic       sync_clear_out,
    output      logic       sync_load_out,
    output      logic       control_one_n_out,
    output      logic       control_two_n_out,
    output      logic       wide_reset_n_out
);
    // lower-order neighbour bit and cascade source
    assign carry_out   = carry_req_in;
    assign cascade_out = cascade_req_in;
    // one clear and one load shared by every register of the cluster
    assign sync_clear_out = clear_req_in;
    assign sync_load_out  = load_req_in;
    // unused async controls sit high; order is {device, two, one}
    assign control_one_n_out = !async_low_req_in[0];
    assign control_two_n_out = !async_low_req_in[1];
    assign wide_reset_n_out  = !async_low_req_in[2];
endmodule // cluster_side_model

// ### tb/logic_cell_tb_top.sv
// self-checking bench for the logic cell
`timescale 1ns/100ps
module logic_cell_tb_top;
    logic                   clock_in, rst_in, carry_r, casc_r, clr_r, ld_r;
    logic                   carry_w, casc_w, clr_w, ld_w, one_n_w, two_n_w, dev_n_w;
    logic [2:0]             alow_r;
    cell_pkg::bus_req_t     bus;
    cell_pkg::cell_inputs_t din;
    logic [31:0]            rdata;
    logic                   cell_o, q_o, carry_o, casc_o, cgen_o, lgen_o;
    int                     miscompares, total_checks, cycles;

    logic_cell dut_u (.clock_in, .rst_in, .bus_in(bus), .rdata_out(rdata), .cell_data_in(din),
        .carry_in(carry_w), .cascade_in(casc_w), .cluster_sync_clear_in(clr_w), .cluster_sync_load_in(ld_w),
        .cluster_control_one_n_in(one_n_w), .cluster_control_two_n_in(two_n_w), .device_wide_reset_n_in(dev_n_w),
        .cell_out(cell_o), .register_q_out(q_o), .carry_out(carry_o), .cascade_out(casc_o),
        .cluster_clear_gen_out(cgen_o), .cluster_load_gen_out(lgen_o));
    cluster_side_model side_u (.carry_req_in(carry_r), .cascade_req_in(casc_r), .clear_req_in(clr_r),
        .load_req_in(ld_r), .async_low_req_in(alow_r), .carry_out(carry_w), .cascade_out(casc_w),
        .sync_clear_out(clr_w), .sync_load_out(ld_w), .control_one_n_out(one_n_w),
        .control_two_n_out(two_n_w), .wide_reset_n_out(dev_n_w));

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = !clock_in;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic access(input logic [3:0] a, input logic [31:0] d, input logic w);
        @(posedge clock_in);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clock_in);
        bus <= '0;
        #1;
    endtask

    task automatic chb(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic wctl(input logic [31:0] d);
        access(cell_pkg::ADDR_CTRL, d, 1'b1);
    endtask

    task automatic wpos(input logic [31:0] d);
        access(cell_pkg::ADDR_POS, d, 1'b1);
    endtask

    task automatic set(input logic [3:0] d, input logic c, input logic k);
        @(posedge clock_in);
        din <= d;
        carry_r <= c;
        casc_r <= k;
        #1;
    endtask

    task automatic ctl(input logic c, input logic l);
        @(posedge clock_in);
        clr_r <= c;
        ld_r <= l;
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // hang guard, far above the run's length
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        {rst_in, carry_r, casc_r, clr_r, ld_r, alow_r, bus, din} = '0;
        {miscompares, total_checks, cycles} = '0;
        rst_in = 1'b1;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        access(cell_pkg::ADDR_CTRL, 32'h0, 1'b0);
        chk("ctrl reset", 32'h0, rdata);
        access(4'h2, 32'h0, 1'b0);
        chk("unmapped read", 32'h0, rdata);
        access(cell_pkg::ADDR_LUT, 32'h6996, 1'b1);
        access(cell_pkg::ADDR_LUT, 32'h0, 1'b0);
        chk("lut readback", 32'h6996, rdata);
        wctl(32'h20);
        for (int i = 0; i < 16; i++)
        begin
            set(i[3:0], 1'b0, 1'b0);
            chb("normal table", ^i[3:0], cell_o);
        end
        wctl(32'h24);
        set(4'h4, 1'b0, 1'b0);
        chb("carry as input", 1'b0, cell_o);
        wctl(32'h28);
        for (int j = 0; j < 4; j++)
        begin
            set({3'h0, j[0]}, 1'b0, j[1]);
            chb("cascade", j[0] & j[1], casc_o);
        end
        wpos(32'h13);
        access(cell_pkg::ADDR_LUT, 32'hE896, 1'b1);
        wctl(32'h29);
        for (int i = 0; i < 8; i++)
        begin
            set({2'h0, i[1:0]}, i[2], 1'b1);
            chb("sum", ^i[2:0], cell_o);
            chb("carry", (i[0] & i[1]) | (i[2] & (i[0] | i[1])), carry_o);
        end
        wctl(32'h01);
        set(4'h1, 1'b0, 1'b0);
        tick(1);
        chb("registered sum", 1'b1, cell_o);
        set(4'h3, 1'b1, 1'b0);
        wpos(32'h99);
        chb("carry to next cluster", 1'b1, carry_o);
        wpos(32'hB9);
        chb("row middle carry", 1'b0, carry_o);
        wpos(32'h10);
        chb("first cell carry", 1'b0, carry_o);
        wctl(32'h1021);
        wpos(32'h15);
        chb("sink output", 1'b1, cell_o);
        chb("sink carry", 1'b0, carry_o);
        wpos(32'h10);
        wctl(32'h2000);
        for (int j = 0; j < 4; j++)
        begin
            set({2'h0, j[1:0]}, 1'b0, 1'b0);
            chk("control gen", {30'h0, j[1:0]}, {30'h0, lgen_o, cgen_o});
        end
        // counter, enable on input one
        wpos(32'h13);
        wctl(32'h03);
        set(4'h1, 1'b1, 1'b0);
        ctl(1'b1, 1'b0);
        ctl(1'b0, 1'b0);
        for (int i = 1; i < 5; i++)
        begin
            tick(1);
            chb("count up", i[0], q_o);
        end
        set(4'h0, 1'b1, 1'b0);
        tick(2);
        chb("count disabled", 1'b1, q_o);
        // direction on input two
        wctl(32'h403);
        ctl(1'b1, 1'b0);
        tick(1);
        chb("down borrow", 1'b1, carry_o);
        set(4'h2, 1'b1, 1'b0);
        chb("up no carry", 1'b0, carry_o);
        set(4'h4, 1'b0, 1'b0);
        ctl(1'b0, 1'b1);
        tick(1);
        chb("load", 1'b1, q_o);
        wctl(32'h40B);
        set(4'h0, 1'b0, 1'b1);
        tick(1);
        chb("load over cascade", 1'b0, q_o);
        set(4'h4, 1'b0, 1'b0);
        ctl(1'b1, 1'b1);
        tick(1);
        chb("clear over load", 1'b0, q_o);
        ctl(1'b0, 1'b1);
        tick(1);
        wctl(32'h603);
        set(4'h0, 1'b1, 1'b0);
        tick(2);
        chb("load holds", 1'b1, q_o);
        // second cell, carry_in low
        ctl(1'b1, 1'b0);
        wpos(32'h11);
        wctl(32'hC03);
        set(4'h2, 1'b0, 1'b0);
        ctl(1'b0, 1'b0);
        tick(1);
        chb("fast feedback", 1'b1, q_o);
        wctl(32'h100);
        set(4'h4, 1'b0, 1'b0);
        ctl(1'b0, 1'b1);
        tick(1);
        ctl(1'b0, 1'b0);
        // async controls move off the edge
        @(negedge clock_in) alow_r <= 3'b001;
        #1 chb("async clear", 1'b0, q_o);
        @(negedge clock_in) alow_r <= 3'b000;
        wctl(32'h140);
        // table gives zero, so q sits low before the reset
        set(4'h0, 1'b0, 1'b0);
        tick(1);
        @(negedge clock_in) alow_r <= 3'b100;
        #1 chb("wide reset preset", 1'b1, q_o);
        @(negedge clock_in) alow_r <= 3'b000;
        tick(2);
        print_verdict();
    end
endmodule // logic_cell_tb_top
